// file: src/pfl_consts.svh
`ifndef PFL_CONSTS_SVH
`define PFL_CONSTS_SVH
// Summary of operation
// - round robin pick after each request completes
// - packet registration writes base and map at once; its flush and done wait for an idle decoder and hold off channel dispatch
// - packet access: cache if piece mapped, else bus
// - context commands use the context store
// - cached read copies; cached write marks dirty
// - eviction writes back dirty longwords first
// - bus side writes only dirty-marked longwords
// - flush on piece replace and on registration of the cached packet
// - context store is slots times context words
// - per slot: base address and 32-bit piece map
// - pending mask bit per waiting channel
// - served channel held for whole request
// - copy in, kick, wait done, copy back
// - longwords big endian, byte 0 most significant
// - registration: base, number, go, done, clear
// - packet read handshake with done flag
// - packet write handshake, acknowledge then clear
// - unsupported operation returns failure code
// - context read follows packet read handshake
// - context write follows packet write handshake
`define PFL_CODE_W 3
`define PFL_CODE_PKT_RD 3'h1
`define PFL_CODE_PKT_WR 3'h2
`define PFL_CODE_CTX_RD 3'h3
`define PFL_CODE_CTX_WR 3'h4
`define PFL_CODE_ACK 3'h5
`define PFL_CODE_FAIL 3'h6
`define PFL_PKT_W 8
`define PFL_OFS_W 16
`define PFL_LW_W 32
`define PFL_MAP_W 32
`define PFL_MAP_IDX_W 5
`define PFL_BYTE_SHIFT 2
`endif

// file: src/pfl_pkg.sv
package pfl_pkg;
`include "pfl_consts.svh"
	typedef struct packed {
		logic [`PFL_CODE_W-1:0] code;
		logic [`PFL_PKT_W-1:0] pkt;
		logic [`PFL_OFS_W-1:0] offset;
	} pfl_cmd_type;
	typedef struct packed {
		logic [`PFL_LW_W-1:0] base;
		logic [`PFL_PKT_W-1:0] pkt;
	} pfl_load_type;
	typedef struct packed {
		logic req;
		logic we;
		logic [`PFL_LW_W-1:0] addr;
		logic [`PFL_LW_W-1:0] wdata;
	} pfl_mem_type;
	typedef enum logic {ARB_IDLE, ARB_WAIT} pfl_arb_state_type;
	typedef enum logic [2:0] {DEC_IDLE, DEC_FLUSH, DEC_MISS, DEC_FILL, DEC_SERVE} pfl_dec_state_type;
endpackage : pfl_pkg

// file: src/pfl_top.sv
`timescale 1ns/1ps
`include "pfl_consts.svh"
module pfl_top #(
	parameter int CHANNELS = 4,
	parameter int SLOTS = 16,
	parameter int CTX_WORDS = 8,
	parameter int CACHE_WORDS = 8,
	parameter bit SUPPORT_READ = 1'b1,
	parameter bit SUPPORT_WRITE = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire pfl_pkg::pfl_cmd_type [CHANNELS-1:0] chan_cmd_in,
	input wire logic [CHANNELS-1:0][`PFL_LW_W-1:0] chan_payload_in,
	input wire logic [CHANNELS-1:0] chan_ask_line,
	input wire logic [CHANNELS-1:0] chan_done_clear,
	output pfl_pkg::pfl_cmd_type [CHANNELS-1:0] chan_cmd_out,
	output logic [CHANNELS-1:0][`PFL_LW_W-1:0] chan_payload_out,
	output logic [CHANNELS-1:0] chan_done_flag,
	input wire pfl_pkg::pfl_load_type load_req,
	input wire logic load_go,
	input wire logic load_done_clear,
	output logic load_done,
	output pfl_pkg::pfl_mem_type mem_out,
	input wire logic mem_ack,
	input wire logic [`PFL_LW_W-1:0] mem_rdata
);
	localparam int CHW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
	localparam int SW = (SLOTS > 1) ? $clog2(SLOTS) : 1;
	localparam int CWB = (CACHE_WORDS > 1) ? $clog2(CACHE_WORDS) : 1;
	localparam int CXW = (SLOTS * CTX_WORDS > 1) ? $clog2(SLOTS * CTX_WORDS) : 1;
	localparam int PIW = `PFL_MAP_IDX_W;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [`PFL_LW_W-1:0] base_mem [SLOTS];
	logic [`PFL_MAP_W-1:0] map_mem [SLOTS];
	logic [`PFL_LW_W-1:0] ctx_mem [SLOTS*CTX_WORDS];
	logic [`PFL_LW_W-1:0] cache_mem [CACHE_WORDS];

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [CHW-1:0] rr_pick(input logic [CHANNELS-1:0] pend,
		input logic [CHW-1:0] last);
		logic [CHW-1:0] idx;
		logic [CHW-1:0] res;
		logic found;
		res = last;
		found = 1'b0;
		for (int i = 1; i <= CHANNELS; i++) begin
			idx = CHW'((int'(last) + i) % CHANNELS);
			if (!found && pend[idx]) begin
				res = idx;
				found = 1'b1;
			end
		end
		return res;
	endfunction : rr_pick

	// byte address of a longword; bytes already sit big endian in the word
	function automatic logic [`PFL_LW_W-1:0] lw_addr(input logic [`PFL_LW_W-1:0] base,
		input logic [PIW-1:0] piece, input logic [CWB-1:0] widx);
		return base + (`PFL_LW_W'({piece, widx}) << `PFL_BYTE_SHIFT);
	endfunction : lw_addr

	// ------------------------------------------------------------
	// arbiter
	// ------------------------------------------------------------
	pfl_pkg::pfl_arb_state_type arb_state_reg, arb_state_next;
	logic [CHW-1:0] cur_chan_reg, cur_chan_next;
	logic [CHANNELS-1:0] pend_reg, pend_next, ask_prev_reg, ask_rise, pend_clr;
	logic [CHANNELS-1:0] done_reg, done_next, done_set;
	pfl_pkg::pfl_cmd_type [CHANNELS-1:0] chan_cmd_reg, chan_cmd_next;
	logic [CHANNELS-1:0][`PFL_LW_W-1:0] chan_payload_reg, chan_payload_next;
	logic kick_reg, kick_next, copy_in;
	logic [CHW-1:0] pick;
	logic dec_done_reg, dec_done_next;
	pfl_pkg::pfl_cmd_type shared_cmd_reg, shared_cmd_next;
	logic [`PFL_LW_W-1:0] shared_data_reg, shared_data_next;
	pfl_pkg::pfl_dec_state_type dec_state_reg, dec_state_next;
	logic store_pend_reg, store_pend_next, store_clr;

	always_comb begin
		ask_rise = chan_ask_line & ~ask_prev_reg;
		arb_state_next = arb_state_reg;
		cur_chan_next = cur_chan_reg;
		kick_next = 1'b0;
		copy_in = 1'b0;
		pend_clr = '0;
		done_set = '0;
		chan_cmd_next = chan_cmd_reg;
		chan_payload_next = chan_payload_reg;
		// next channel after the last one served
		pick = rr_pick(pend_reg, cur_chan_reg);
		case (arb_state_reg)
			pfl_pkg::ARB_IDLE: begin
				// kick is a single pulse: a busy decoder would lose it and hang the channel
				if (pend_reg != '0 && dec_state_reg == pfl_pkg::DEC_IDLE
					&& !store_pend_reg) begin
					// copy in and kick the decoder
					cur_chan_next = pick;
					pend_clr[pick] = 1'b1;
					copy_in = 1'b1;
					kick_next = 1'b1;
					arb_state_next = pfl_pkg::ARB_WAIT;
				end
			end
			pfl_pkg::ARB_WAIT: begin
				if (dec_done_reg) begin
					chan_cmd_next[cur_chan_reg] = shared_cmd_reg;
					chan_payload_next[cur_chan_reg] = shared_data_reg;
					done_set[cur_chan_reg] = 1'b1;
					arb_state_next = pfl_pkg::ARB_IDLE;
				end
			end
			default: arb_state_next = pfl_pkg::ARB_IDLE;
		endcase
		// a new ask beats the clear of the pick
		pend_next = (pend_reg & ~pend_clr) | ask_rise;
		// done flag stays until the channel clears it
		done_next = (done_reg & ~chan_done_clear) | done_set;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			arb_state_reg <= pfl_pkg::ARB_IDLE;
			cur_chan_reg <= '0;
			pend_reg <= '0;
			ask_prev_reg <= '0;
			done_reg <= '0;
			chan_cmd_reg <= '0;
			chan_payload_reg <= '0;
			kick_reg <= 1'b0;
		end else begin
			arb_state_reg <= arb_state_next;
			cur_chan_reg <= cur_chan_next;
			pend_reg <= pend_next;
			ask_prev_reg <= chan_ask_line;
			done_reg <= done_next;
			chan_cmd_reg <= chan_cmd_next;
			chan_payload_reg <= chan_payload_next;
			kick_reg <= kick_next;
		end
	end

	assign chan_cmd_out = chan_cmd_reg;
	assign chan_payload_out = chan_payload_reg;
	assign chan_done_flag = done_reg;

	// ------------------------------------------------------------
	// decoder, cache and bus side unit
	// ------------------------------------------------------------
	logic [CWB:0] word_cnt_reg, word_cnt_next;
	logic store_mode_reg, store_mode_next;
	logic [SW-1:0] store_slot_reg, store_slot_next;
	logic load_done_reg, load_done_next, load_done_set;
	logic cache_valid_reg, cache_valid_next;
	logic [SW-1:0] cache_slot_reg, cache_slot_next;
	logic [PIW-1:0] cache_piece_reg, cache_piece_next;
	logic [`PFL_LW_W-1:0] cache_base_reg, cache_base_next;
	logic [CACHE_WORDS-1:0] dirty_reg, dirty_next;
	pfl_pkg::pfl_mem_type mem_reg, mem_next;
	logic cache_we, ctx_we, map_we, map_val;
	logic [CWB-1:0] cache_widx, lw_idx, cur_word;
	logic [`PFL_LW_W-1:0] cache_wdata;
	logic [CXW-1:0] ctx_idx;
	logic [PIW-1:0] piece;
	logic [SW-1:0] slot;
	logic bad_pkt, bad_ofs, is_rd, hit;

	always_comb begin
		dec_state_next = dec_state_reg;
		word_cnt_next = word_cnt_reg;
		store_mode_next = store_mode_reg;
		store_clr = 1'b0;
		load_done_set = 1'b0;
		cache_valid_next = cache_valid_reg;
		cache_slot_next = cache_slot_reg;
		cache_piece_next = cache_piece_reg;
		cache_base_next = cache_base_reg;
		dirty_next = dirty_reg;
		mem_next = mem_reg;
		shared_cmd_next = shared_cmd_reg;
		shared_data_next = shared_data_reg;
		dec_done_next = 1'b0;
		cache_we = 1'b0;
		cache_widx = '0;
		cache_wdata = mem_rdata;
		ctx_we = 1'b0;
		map_we = 1'b0;
		map_val = 1'b0;
		slot = SW'(shared_cmd_reg.pkt);
		lw_idx = shared_cmd_reg.offset[CWB-1:0];
		piece = shared_cmd_reg.offset[CWB+PIW-1:CWB];
		cur_word = word_cnt_reg[CWB-1:0];
		ctx_idx = CXW'(int'(shared_cmd_reg.pkt) * CTX_WORDS + int'(shared_cmd_reg.offset));
		bad_pkt = int'(shared_cmd_reg.pkt) >= SLOTS;
		bad_ofs = (shared_cmd_reg.offset >> (CWB + PIW)) != '0;
		is_rd = shared_cmd_reg.code == `PFL_CODE_PKT_RD;
		hit = !bad_pkt && map_mem[slot][piece];
		if (copy_in) begin
			shared_cmd_next = chan_cmd_in[pick];
			shared_data_next = chan_payload_in[pick];
		end
		case (dec_state_reg)
			pfl_pkg::DEC_IDLE: begin
				if (kick_reg) begin
					dec_done_next = 1'b1;
					shared_cmd_next.code = `PFL_CODE_FAIL;
					case (shared_cmd_reg.code)
						`PFL_CODE_CTX_RD, `PFL_CODE_CTX_WR: begin
							if (!bad_pkt && int'(shared_cmd_reg.offset) < CTX_WORDS) begin
								shared_cmd_next.code = `PFL_CODE_ACK;
								if (shared_cmd_reg.code == `PFL_CODE_CTX_RD) begin
									shared_data_next = ctx_mem[ctx_idx];
								end else begin
									ctx_we = 1'b1;
								end
							end
						end
						`PFL_CODE_PKT_RD, `PFL_CODE_PKT_WR: begin
							if (!((is_rd && !SUPPORT_READ) || (!is_rd && !SUPPORT_WRITE)
								|| bad_pkt || bad_ofs)) begin
								dec_done_next = 1'b0;
								shared_cmd_next.code = shared_cmd_reg.code;
								// mapped piece served locally, else via bus
								if (hit) begin
									dec_state_next = pfl_pkg::DEC_SERVE;
								end else if (cache_valid_reg) begin
									store_mode_next = 1'b0;
									word_cnt_next = '0;
									dec_state_next = pfl_pkg::DEC_FLUSH;
								end else begin
									dec_state_next = pfl_pkg::DEC_MISS;
								end
							end
						end
						default: ;
					endcase
				end else if (store_pend_reg) begin
					// registration flushes the old packet if cached
					if (cache_valid_reg && cache_slot_reg == store_slot_reg) begin
						store_mode_next = 1'b1;
						word_cnt_next = '0;
						dec_state_next = pfl_pkg::DEC_FLUSH;
					end else begin
						store_clr = 1'b1;
						load_done_set = 1'b1;
					end
				end
			end
			pfl_pkg::DEC_FLUSH: begin
				if (!mem_reg.req) begin
					if (int'(word_cnt_reg) == CACHE_WORDS) begin
						map_we = 1'b1;
						cache_valid_next = 1'b0;
						dirty_next = '0;
						if (store_mode_reg) begin
							store_clr = 1'b1;
							load_done_set = 1'b1;
							dec_state_next = pfl_pkg::DEC_IDLE;
						end else begin
							dec_state_next = pfl_pkg::DEC_MISS;
						end
					end else if (dirty_reg[cur_word]) begin
						mem_next.req = 1'b1;
						mem_next.we = 1'b1;
						// word order in memory is address order
						mem_next.addr = lw_addr(cache_base_reg, cache_piece_reg, cur_word);
						mem_next.wdata = cache_mem[cur_word];
					end else begin
						word_cnt_next = word_cnt_reg + 1'b1;
					end
				end else if (mem_ack) begin
					mem_next.req = 1'b0;
					word_cnt_next = word_cnt_reg + 1'b1;
				end
			end
			pfl_pkg::DEC_MISS: begin
				cache_slot_next = slot;
				cache_piece_next = piece;
				cache_base_next = base_mem[slot];
				dirty_next = '0;
				word_cnt_next = '0;
				dec_state_next = pfl_pkg::DEC_FILL;
			end
			pfl_pkg::DEC_FILL: begin
				if (!mem_reg.req) begin
					if (int'(word_cnt_reg) == CACHE_WORDS) begin
						map_we = 1'b1;
						map_val = 1'b1;
						cache_valid_next = 1'b1;
						dec_state_next = pfl_pkg::DEC_SERVE;
					end else begin
						mem_next.req = 1'b1;
						mem_next.we = 1'b0;
						mem_next.addr = lw_addr(cache_base_reg, cache_piece_reg, cur_word);
					end
				end else if (mem_ack) begin
					mem_next.req = 1'b0;
					cache_we = 1'b1;
					cache_widx = cur_word;
					word_cnt_next = word_cnt_reg + 1'b1;
				end
			end
			pfl_pkg::DEC_SERVE: begin
				// cached read copies, cached write marks dirty
				if (is_rd) begin
					shared_data_next = cache_mem[lw_idx];
				end else begin
					cache_we = 1'b1;
					cache_widx = lw_idx;
					cache_wdata = shared_data_reg;
					dirty_next[lw_idx] = 1'b1;
				end
				shared_cmd_next.code = `PFL_CODE_ACK;
				dec_done_next = 1'b1;
				dec_state_next = pfl_pkg::DEC_IDLE;
			end
			default: dec_state_next = pfl_pkg::DEC_IDLE;
		endcase
		// registration accepted in any decoder state
		store_pend_next = (store_pend_reg & ~store_clr) | load_go;
		store_slot_next = load_go ? SW'(load_req.pkt) : store_slot_reg;
		// done flag set wins over its clear
		load_done_next = (load_done_reg & ~load_done_clear) | load_done_set;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dec_state_reg <= pfl_pkg::DEC_IDLE;
			word_cnt_reg <= '0;
			store_mode_reg <= 1'b0;
			store_pend_reg <= 1'b0;
			store_slot_reg <= '0;
			load_done_reg <= 1'b0;
			cache_valid_reg <= 1'b0;
			cache_slot_reg <= '0;
			cache_piece_reg <= '0;
			cache_base_reg <= '0;
			dirty_reg <= '0;
			mem_reg <= '0;
			shared_cmd_reg <= '0;
			shared_data_reg <= '0;
			dec_done_reg <= 1'b0;
			for (int i = 0; i < SLOTS; i++) begin
				map_mem[i] <= '0;
			end
		end else begin
			dec_state_reg <= dec_state_next;
			word_cnt_reg <= word_cnt_next;
			store_mode_reg <= store_mode_next;
			store_pend_reg <= store_pend_next;
			store_slot_reg <= store_slot_next;
			load_done_reg <= load_done_next;
			cache_valid_reg <= cache_valid_next;
			cache_slot_reg <= cache_slot_next;
			cache_piece_reg <= cache_piece_next;
			cache_base_reg <= cache_base_next;
			dirty_reg <= dirty_next;
			mem_reg <= mem_next;
			shared_cmd_reg <= shared_cmd_next;
			shared_data_reg <= shared_data_next;
			dec_done_reg <= dec_done_next;
			if (map_we) begin
				map_mem[cache_slot_reg][cache_piece_reg] <= map_val;
			end
			// registration writes base, empties piece map
			if (load_go && int'(load_req.pkt) < SLOTS) begin
				map_mem[SW'(load_req.pkt)] <= '0;
			end
		end
	end

	// data arrays carry no reset
	always_ff @(posedge sys_clk) begin
		if (load_go && int'(load_req.pkt) < SLOTS) begin
			base_mem[SW'(load_req.pkt)] <= load_req.base;
		end
		if (cache_we) begin
			cache_mem[cache_widx] <= cache_wdata;
		end
		if (ctx_we) begin
			ctx_mem[ctx_idx] <= shared_data_reg;
		end
	end

	assign load_done = load_done_reg;
	assign mem_out = mem_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_pend_set_on_ask: assert property (ask_rise[0] |=> pend_reg[0])
		else $error("new ask not recorded as pending");
	a_chan_held_wait: assert property (arb_state_reg == pfl_pkg::ARB_WAIT && !dec_done_reg
		|=> $stable(cur_chan_reg))
		else $error("served channel changed during request");
	a_kick_then_wait: assert property (kick_reg |-> arb_state_reg == pfl_pkg::ARB_WAIT
		&& $past(arb_state_reg) == pfl_pkg::ARB_IDLE)
		else $error("kick outside dispatch");
	a_done_copy_back: assert property (arb_state_reg == pfl_pkg::ARB_WAIT && dec_done_reg
		|=> done_reg[$past(cur_chan_reg)] && chan_cmd_reg[$past(cur_chan_reg)]
		== $past(shared_cmd_reg))
		else $error("result not copied back with done");
	a_ctx_one_cycle: assert property (kick_reg && (shared_cmd_reg.code == `PFL_CODE_CTX_RD
		|| shared_cmd_reg.code == `PFL_CODE_CTX_WR) |=> dec_done_reg && !mem_reg.req)
		else $error("context access not answered next cycle");
	a_ctx_range_fail: assert property (kick_reg && shared_cmd_reg.code == `PFL_CODE_CTX_RD
		&& int'(shared_cmd_reg.offset) >= CTX_WORDS
		|=> shared_cmd_reg.code == `PFL_CODE_FAIL)
		else $error("out of range context read not failed");
	a_hit_serves_local: assert property (kick_reg && dec_state_reg == pfl_pkg::DEC_IDLE
		&& shared_cmd_reg.code == `PFL_CODE_PKT_RD && !bad_ofs && hit
		|=> dec_state_reg == pfl_pkg::DEC_SERVE ##1 dec_done_reg)
		else $error("mapped piece not served from cache");
	a_write_dirty: assert property (dec_state_reg == pfl_pkg::DEC_SERVE && !is_rd
		|=> dirty_reg[$past(lw_idx)])
		else $error("cached write left longword clean");
	a_flush_dirty_only: assert property (mem_reg.req && mem_reg.we
		|-> dec_state_reg == pfl_pkg::DEC_FLUSH && dirty_reg[cur_word])
		else $error("write-back of a clean longword");
	a_load_done_holds: assert property (load_done_reg && !load_done_clear |=> load_done_reg)
		else $error("load done dropped without clear");

	c_ctx_write: cover property (kick_reg && shared_cmd_reg.code == `PFL_CODE_CTX_WR);
	c_miss_fill: cover property (dec_state_reg == pfl_pkg::DEC_FILL ##[1:60] dec_done_reg);
	c_evict_dirty: cover property (dec_state_reg == pfl_pkg::DEC_FLUSH && mem_reg.we);
	c_two_channels: cover property (pend_reg[0] && pend_reg[1]);
endmodule : pfl_top

// file: dv/pfl_mem_model.sv
`timescale 1ns/1ps
module pfl_mem_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire pfl_pkg::pfl_mem_type mem_out,
	input wire logic slow,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	output int wr_count
);
	logic [31:0] mem [0:255];
	int wait_cnt;

	// ----------------------------------------
	// backing store
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 32'hC0DE0000 | i;
		end
	end

	// ----------------------------------------
	// access handling
	// ----------------------------------------
	// released data bus toggles every cycle so stale data never looks valid
	always @(posedge sys_clk) begin
		mem_rdata <= ~mem_rdata;
		if (rst) begin
			mem_ack <= 1'b0;
			wait_cnt <= 0;
			wr_count <= 0;
		end else if (mem_ack || !mem_out.req) begin
			mem_ack <= 1'b0;
			wait_cnt <= 0;
		end else if (wait_cnt < (slow ? 3 : 0)) begin
			wait_cnt <= wait_cnt + 1;
		end else begin
			mem_ack <= 1'b1;
			wait_cnt <= 0;
			if (mem_out.we) begin
				mem[mem_out.addr[9:2]] <= mem_out.wdata;
				wr_count <= wr_count + 1;
			end else begin
				mem_rdata <= mem[mem_out.addr[9:2]];
			end
		end
	end
endmodule : pfl_mem_model

// file: dv/pfl_top_bench.sv
`timescale 1ns/1ps
`include "pfl_consts.svh"
module pfl_top_bench;
	localparam int CH = 4;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	pfl_pkg::pfl_cmd_type [CH-1:0] chan_cmd_in = '0;
	logic [CH-1:0][31:0] chan_payload_in = '0;
	logic [CH-1:0] chan_ask_line = '0;
	logic [CH-1:0] chan_done_clear = '0;
	pfl_pkg::pfl_cmd_type [CH-1:0] chan_cmd_out;
	logic [CH-1:0][31:0] chan_payload_out;
	logic [CH-1:0] chan_done_flag;
	pfl_pkg::pfl_load_type load_req = '0;
	logic load_go = 1'b0;
	logic load_done_clear = 1'b0;
	logic load_done;
	pfl_pkg::pfl_mem_type mem_out;
	logic mem_ack;
	logic [31:0] mem_rdata;
	logic slow = 1'b0;
	int wr_count;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;

	always #5 sys_clk = ~sys_clk;

	pfl_top #(.CHANNELS(CH), .SLOTS(16), .CTX_WORDS(8), .CACHE_WORDS(8)) i_pfl_top (
		.sys_clk(sys_clk),
		.rst(rst),
		.chan_cmd_in(chan_cmd_in),
		.chan_payload_in(chan_payload_in),
		.chan_ask_line(chan_ask_line),
		.chan_done_clear(chan_done_clear),
		.chan_cmd_out(chan_cmd_out),
		.chan_payload_out(chan_payload_out),
		.chan_done_flag(chan_done_flag),
		.load_req(load_req),
		.load_go(load_go),
		.load_done_clear(load_done_clear),
		.load_done(load_done),
		.mem_out(mem_out),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata)
	);

	pfl_mem_model i_pfl_mem_model (
		.sys_clk(sys_clk),
		.rst(rst),
		.mem_out(mem_out),
		.slow(slow),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata),
		.wr_count(wr_count)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finish_test;
		$display("mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_flag(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_flag

	// inputs always change 1 ns after the rising edge
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask : tick

	task automatic start_op(input int ch, input logic [2:0] code, input logic [7:0] pkt,
		input logic [15:0] ofs, input logic [31:0] data);
		chan_cmd_in[ch] = '{code: code, pkt: pkt, offset: ofs};
		chan_payload_in[ch] = data;
		chan_ask_line[ch] = 1'b1;
	endtask : start_op

	task automatic wait_done(input int ch);
		int n;
		n = 0;
		while (chan_done_flag[ch] !== 1'b1 && n < 400) begin
			tick;
			n++;
		end
		check_flag(chan_done_flag[ch], 1'b1);
	endtask : wait_done

	// done must stay up until cleared, then drop
	task automatic end_op(input int ch, input logic [2:0] code, input logic [31:0] data,
		input bit chk);
		wait_done(ch);
		check_word({29'h0, chan_cmd_out[ch].code}, {29'h0, code});
		if (chk) begin
			check_word(chan_payload_out[ch], data);
		end
		chan_ask_line[ch] = 1'b0;
		chan_done_clear[ch] = 1'b1;
		tick;
		chan_done_clear[ch] = 1'b0;
		tick;
		check_flag(chan_done_flag[ch], 1'b0);
	endtask : end_op

	task automatic op(input int ch, input logic [2:0] code, input logic [7:0] pkt,
		input logic [15:0] ofs, input logic [31:0] data, input logic [2:0] exp_code,
		input logic [31:0] exp_data, input bit chk);
		tick;
		start_op(ch, code, pkt, ofs, data);
		end_op(ch, exp_code, exp_data, chk);
	endtask : op

	task automatic load_pkt(input logic [7:0] pkt, input logic [31:0] base);
		int n;
		tick;
		load_req = '{base: base, pkt: pkt};
		load_go = 1'b1;
		tick;
		load_go = 1'b0;
		n = 0;
		while (load_done !== 1'b1 && n < 400) begin
			tick;
			n++;
		end
		check_flag(load_done, 1'b1);
		load_done_clear = 1'b1;
		tick;
		load_done_clear = 1'b0;
		tick;
		check_flag(load_done, 1'b0);
	endtask : load_pkt

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_cache;
		load_pkt(8'h03, 32'h0000_0100);
		slow = 1'b1;
		op(0, `PFL_CODE_PKT_RD, 8'h03, 16'h0001, 32'h0, `PFL_CODE_ACK, 32'hC0DE0041, 1);
		slow = 1'b0;
		op(1, `PFL_CODE_PKT_WR, 8'h03, 16'h0002, 32'h01020304, `PFL_CODE_ACK, 32'h01020304,
			1);
		check_word(wr_count, 32'h0);
		op(2, `PFL_CODE_PKT_RD, 8'h03, 16'h0002, 32'h0, `PFL_CODE_ACK, 32'h01020304, 1);
		// other piece evicts the dirty one first
		op(3, `PFL_CODE_PKT_RD, 8'h03, 16'h0008, 32'h0, `PFL_CODE_ACK, 32'hC0DE0048, 1);
		check_word(wr_count, 32'h1);
		check_word(i_pfl_mem_model.mem[8'h42], 32'h01020304);
		op(0, `PFL_CODE_PKT_WR, 8'h03, 16'h0009, 32'hAABBCCDD, `PFL_CODE_ACK, 32'hAABBCCDD,
			1);
		load_pkt(8'h03, 32'h0000_0100);
		check_word(wr_count, 32'h2);
		check_word(i_pfl_mem_model.mem[8'h49], 32'hAABBCCDD);
		op(1, `PFL_CODE_PKT_RD, 8'h03, 16'h0009, 32'h0, `PFL_CODE_ACK, 32'hAABBCCDD, 1);
	endtask : t_cache

	task automatic t_context;
		op(2, `PFL_CODE_CTX_WR, 8'h05, 16'h0007, 32'h5EED0007, `PFL_CODE_ACK, 32'h5EED0007,
			1);
		op(3, `PFL_CODE_CTX_WR, 8'h0F, 16'h0000, 32'h0F000000, `PFL_CODE_ACK, 32'h0F000000,
			1);
		op(0, `PFL_CODE_CTX_RD, 8'h05, 16'h0007, 32'h0, `PFL_CODE_ACK, 32'h5EED0007, 1);
		op(1, `PFL_CODE_CTX_RD, 8'h0F, 16'h0000, 32'h0, `PFL_CODE_ACK, 32'h0F000000, 1);
		check_word(wr_count, 32'h2);
	endtask : t_context

	task automatic t_refuse;
		op(2, `PFL_CODE_CTX_RD, 8'h05, 16'h0008, 32'h0, `PFL_CODE_FAIL, 0, 0);
		op(3, `PFL_CODE_CTX_RD, 8'h10, 16'h0000, 32'h0, `PFL_CODE_FAIL, 0, 0);
		op(0, 3'h0, 8'h05, 16'h0000, 32'h0, `PFL_CODE_FAIL, 0, 0);
		op(1, 3'h7, 8'h05, 16'h0000, 32'h0, `PFL_CODE_FAIL, 0, 0);
		op(2, `PFL_CODE_PKT_RD, 8'h03, 16'h0100, 32'h0, `PFL_CODE_FAIL, 0, 0);
	endtask : t_refuse

	// fixed priority either way fails one of the two rounds
	task automatic t_round_robin;
		op(0, `PFL_CODE_CTX_RD, 8'h05, 16'h0007, 32'h0, `PFL_CODE_ACK, 32'h5EED0007, 1);
		tick;
		start_op(0, `PFL_CODE_CTX_RD, 8'h05, 16'h0007, 32'h0);
		start_op(1, `PFL_CODE_CTX_RD, 8'h0F, 16'h0000, 32'h0);
		wait_done(1);
		check_flag(chan_done_flag[0], 1'b0);
		end_op(1, `PFL_CODE_ACK, 32'h0F000000, 1);
		end_op(0, `PFL_CODE_ACK, 32'h5EED0007, 1);
		tick;
		start_op(3, `PFL_CODE_CTX_RD, 8'h05, 16'h0007, 32'h0);
		start_op(1, `PFL_CODE_CTX_RD, 8'h0F, 16'h0000, 32'h0);
		wait_done(1);
		check_flag(chan_done_flag[3], 1'b0);
		end_op(1, `PFL_CODE_ACK, 32'h0F000000, 1);
		end_op(3, `PFL_CODE_ACK, 32'h5EED0007, 1);
	endtask : t_round_robin

	// ----------------------------------------
	// main sequence and hang guard
	// ----------------------------------------
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			finish_test;
		end
	end

	initial begin
		repeat (16) tick;
		rst = 1'b0;
		t_cache;
		t_context;
		t_refuse;
		t_round_robin;
		finish_test;
	end
endmodule : pfl_top_bench
